//--- rmc_chk_properties.sv
// Concurrent checks on the mode controller ports, bound into rmc_ctrl
`timescale 1ns/1ps
`default_nettype none

module rmc_chk
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       wor_tx_role,
   input wire logic       uart_rx_ready,
   input wire logic       uart_tx_valid,
   input wire logic       uart_tx_ready,
   input wire logic [7:0] uart_tx_data,
   input wire logic       radio_tx_wake,
   input wire logic       radio_rx_valid,
   input wire logic       radio_rx_ready,
   input wire logic [7:0] radio_rx_data,
   input wire logic       radio_tx_en,
   input wire logic       radio_rx_en,
   input wire logic       busy_n,
   input wire logic [1:0] mode
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (srst);

   a_radio_on: assert property (!mode[1] |-> radio_tx_en && radio_rx_en)
      else $error("radio path off in normal or wake mode");
   a_radio_off: assert property (
      mode[1] |-> !radio_tx_en && !radio_rx_en && !radio_rx_ready)
      else $error("radio path on in config or sleep mode");
   a_sleep_deaf: assert property (mode == 2'h3 |-> !uart_rx_ready)
      else $error("serial input accepted in sleep mode");
   a_wake_flag: assert property (radio_tx_wake == (mode == 2'h1 && wor_tx_role))
      else $error("wake preamble request wrong for mode");
   a_rx_forward: assert property (
      radio_rx_valid && radio_rx_ready |=> uart_tx_valid && uart_tx_data == $past(radio_rx_data))
      else $error("radio byte not forwarded to serial");
   // Nine low cycles, one per register reloaded from the kept copy
   a_sleep_reload: assert property (
      mode == 2'h3 ##1 mode != 2'h3 |-> !busy_n [*8] ##1 !busy_n ##1 busy_n)
      else $error("reload after sleep not nine cycles busy");
   a_busy_freeze: assert property (!busy_n |=> $stable(mode))
      else $error("mode changed while busy");
   a_tx_hold: assert property (
      uart_tx_valid && !uart_tx_ready |=> uart_tx_valid && $stable(uart_tx_data))
      else $error("serial output dropped before accepted");
endmodule // rmc_chk

bind rmc_ctrl rmc_chk rmc_chk_inst
(
   .clk(clk), .srst(srst), .wor_tx_role(wor_tx_role), .uart_rx_ready(uart_rx_ready),
   .uart_tx_valid(uart_tx_valid), .uart_tx_ready(uart_tx_ready), .uart_tx_data(uart_tx_data),
   .radio_tx_wake(radio_tx_wake), .radio_rx_valid(radio_rx_valid),
   .radio_rx_ready(radio_rx_ready), .radio_rx_data(radio_rx_data), .radio_tx_en(radio_tx_en),
   .radio_rx_en(radio_rx_en), .busy_n(busy_n), .mode(mode)
);
`default_nettype wire

//--- rmc_ctrl.v
// Mode controller and configuration command interpreter of a serial radio modem
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.vh"

module rmc_ctrl
(
   input  wire                         clk,
   input  wire                         srst,
   input  wire                         mode_select_low,
   input  wire                         mode_select_high,
   input  wire                         wor_tx_role,
   input  wire                         uart_rx_valid,
   output wire                         uart_rx_ready,
   input  wire [7:0]                   uart_rx_data,
   output wire                         uart_tx_valid,
   input  wire                         uart_tx_ready,
   output wire [7:0]                   uart_tx_data,
   output wire                         radio_tx_valid,
   input  wire                         radio_tx_ready,
   output wire [7:0]                   radio_tx_data,
   output wire                         radio_tx_wake,
   input  wire                         radio_busy,
   input  wire                         radio_rx_valid,
   output wire                         radio_rx_ready,
   input  wire [7:0]                   radio_rx_data,
   output wire                         radio_tx_en,
   output wire                         radio_rx_en,
   output wire                         busy_n,
   output wire [1:0]                   mode,
   output wire [8*`RMC_REG_NUM-1:0]    cfg_live,
   output wire [8*`RMC_REG_NUM-1:0]    cfg_stored
);

   // ****************************************
   // Parser states
   // ****************************************
   localparam ST_IDLE = 3'h0;
   localparam ST_WRAP = 3'h1;
   localparam ST_HDR  = 3'h2;
   localparam ST_ADDR = 3'h3;
   localparam ST_LEN  = 3'h4;
   localparam ST_DATA = 3'h5;
   localparam ST_RESP = 3'h6;
   localparam ST_ERR  = 3'h7;

   reg  [1:0]                 pin_meta_reg;
   reg  [1:0]                 pin_sync_reg;
   reg  [1:0]                 mode_reg;
   reg                        reload_reg;
   reg  [`RMC_REG_IDX_W-1:0]  reload_idx_reg;
   reg  [2:0]                 state_reg;
   reg  [2:0]                 state_next;
   reg  [7:0]                 cmd_reg;
   reg                        wrap_reg;
   reg  [7:0]                 addr_reg;
   reg  [7:0]                 len_reg;
   reg  [7:0]                 cnt_reg;
   reg  [7:0]                 idx_reg;
   reg                        tx_valid_reg;
   reg  [7:0]                 tx_data_reg;
   reg  [7:0]                 rsp_byte;
   reg  [7:0]                 rsp_last;
   reg  [7:0]                 rsp_k;
   wire [7:0]                 live_q [0:`RMC_REG_NUM-1];
   wire [7:0]                 wr_ptr;
   wire [8:0]                 end_addr;
   wire                       mode_norm;
   wire                       mode_cfg;
   wire                       rx_take;
   wire                       wr_stb;
   wire                       tx_slot;
   wire                       rsp_load;
   wire                       fifo_in_ready;
   wire                       fifo_empty;
   wire                       busy;

   // ****************************************
   // Mode pin capture and mode decode
   // ****************************************
   always @(posedge clk)
   begin
      if (srst)
      begin
         pin_meta_reg <= 2'h0;
         pin_sync_reg <= 2'h0;
      end
      else
      begin
         pin_meta_reg <= {mode_select_high, mode_select_low};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Any pending work keeps the device busy; pins are not looked at then
   assign busy = reload_reg | ~fifo_empty | radio_busy | tx_valid_reg
               | (state_reg != ST_IDLE);
   assign busy_n = ~busy;

   always @(posedge clk)
   begin
      if (srst)
      begin
         mode_reg       <= `RMC_MODE_NORMAL;
         reload_reg     <= 1'b0;
         reload_idx_reg <= {`RMC_REG_IDX_W{1'b0}};
      end
      else if (reload_reg)
      begin
         // One register restored per cycle
         if (reload_idx_reg == `RMC_REG_NUM - 1)
         begin
            reload_reg <= 1'b0;
         end
         reload_idx_reg <= reload_idx_reg + 1'b1;
      end
      else if (~busy && (pin_sync_reg != mode_reg))
      begin
         mode_reg <= pin_sync_reg;
         if (mode_reg == `RMC_MODE_SLEEP)
         begin
            reload_reg     <= 1'b1;
            reload_idx_reg <= {`RMC_REG_IDX_W{1'b0}};
         end
      end
   end

   assign mode      = mode_reg;
   assign mode_norm = (mode_reg == `RMC_MODE_NORMAL) | (mode_reg == `RMC_MODE_WOR);
   assign mode_cfg  = (mode_reg == `RMC_MODE_CFG);

   // Radio is off in config and sleep modes
   assign radio_tx_en   = mode_norm;
   assign radio_rx_en   = mode_norm;
   assign radio_tx_wake = (mode_reg == `RMC_MODE_WOR) & wor_tx_role;

   // ****************************************
   // Serial to radio path
   // ****************************************
   rmc_fifo
   #(
      .WIDTH (`RMC_FIFO_WIDTH),
      .DEPTH (`RMC_FIFO_DEPTH),
      .AW    (`RMC_FIFO_AW)
   )
   u_fifo
   (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (uart_rx_valid & mode_norm),
      .in_ready  (fifo_in_ready),
      .in_data   (uart_rx_data),
      .out_valid (radio_tx_valid),
      .out_ready (radio_tx_ready & mode_norm),
      .out_data  (radio_tx_data),
      .empty     (fifo_empty)
   );

   // Sleep refuses serial input entirely; config takes it only while parsing
   assign rx_take       = mode_cfg & (state_reg < ST_RESP);
   assign uart_rx_ready = mode_norm ? fifo_in_ready : rx_take;

   // ****************************************
   // Serial output holding register
   // ****************************************
   assign tx_slot        = ~tx_valid_reg | uart_tx_ready;
   assign radio_rx_ready = mode_norm & tx_slot;
   assign rsp_load       = tx_slot & ((state_reg == ST_RESP) | (state_reg == ST_ERR));

   always @(posedge clk)
   begin
      if (srst)
      begin
         tx_valid_reg <= 1'b0;
         tx_data_reg  <= 8'h00;
      end
      else if (rsp_load)
      begin
         tx_valid_reg <= 1'b1;
         tx_data_reg  <= rsp_byte;
      end
      else if (radio_rx_ready & radio_rx_valid)
      begin
         tx_valid_reg <= 1'b1;
         tx_data_reg  <= radio_rx_data;
      end
      else if (uart_tx_ready)
      begin
         tx_valid_reg <= 1'b0;
      end
   end

   assign uart_tx_valid = tx_valid_reg;
   assign uart_tx_data  = tx_data_reg;

   // ****************************************
   // Response byte selection
   // ****************************************
   always @*
   begin
      rsp_k    = idx_reg - (wrap_reg ? 8'h02 : 8'h00);
      rsp_last = len_reg + (wrap_reg ? 8'h04 : 8'h02);
      rsp_byte = `RMC_RSP_ERR;
      if (state_reg == ST_ERR)
      begin
         rsp_last = 8'h02;
         rsp_byte = `RMC_RSP_ERR;
      end
      else if (wrap_reg && (idx_reg < 8'h02))
      begin
         rsp_byte = `RMC_CMD_WRAP;
      end
      else if (rsp_k == 8'h00)
      begin
         rsp_byte = `RMC_RSP_HDR;
      end
      else if (rsp_k == 8'h01)
      begin
         rsp_byte = addr_reg;
      end
      else if (rsp_k == 8'h02)
      begin
         rsp_byte = len_reg;
      end
      else
      begin
         rsp_byte = live_q[rsp_k[`RMC_REG_IDX_W-1:0] + addr_reg[`RMC_REG_IDX_W-1:0]
                           - `RMC_REG_IDX_W'h3];
      end
   end

   // ****************************************
   // Command parser
   // ****************************************
   assign end_addr = {1'b0, addr_reg} + {1'b0, uart_rx_data};

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (uart_rx_valid & rx_take)
            begin
               case (uart_rx_data)
                  `RMC_CMD_SET, `RMC_CMD_READ, `RMC_CMD_TEMP: state_next = ST_ADDR;
                  `RMC_CMD_WRAP: state_next = ST_WRAP;
                  default: state_next = ST_ERR;
               endcase
            end
         end
         ST_WRAP:
         begin
            if (uart_rx_valid)
            begin
               state_next = (uart_rx_data == `RMC_CMD_WRAP) ? ST_HDR : ST_ERR;
            end
         end
         ST_HDR:
         begin
            if (uart_rx_valid)
            begin
               if ((uart_rx_data == `RMC_CMD_SET) || (uart_rx_data == `RMC_CMD_READ)
                   || (uart_rx_data == `RMC_CMD_TEMP))
               begin
                  state_next = ST_ADDR;
               end
               else
               begin
                  state_next = ST_ERR;
               end
            end
         end
         ST_ADDR:
         begin
            if (uart_rx_valid)
            begin
               state_next = (uart_rx_data < `RMC_REG_NUM_B) ? ST_LEN : ST_ERR;
            end
         end
         ST_LEN:
         begin
            if (uart_rx_valid)
            begin
               // Zero length or a span past the last register is malformed
               if ((uart_rx_data == 8'h00) || (end_addr > {1'b0, `RMC_REG_NUM_B}))
               begin
                  state_next = ST_ERR;
               end
               else
               begin
                  state_next = (cmd_reg == `RMC_CMD_READ) ? ST_RESP : ST_DATA;
               end
            end
         end
         ST_DATA:
         begin
            if (uart_rx_valid && (cnt_reg == len_reg - 8'h01))
            begin
               state_next = ST_RESP;
            end
         end
         ST_RESP, ST_ERR:
         begin
            if (rsp_load && (idx_reg == rsp_last))
            begin
               state_next = ST_IDLE;
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= ST_IDLE;
         cmd_reg   <= 8'h00;
         wrap_reg  <= 1'b0;
         addr_reg  <= 8'h00;
         len_reg   <= 8'h00;
         cnt_reg   <= 8'h00;
         idx_reg   <= 8'h00;
      end
      else
      begin
         state_reg <= state_next;
         if ((state_reg == ST_IDLE) && uart_rx_valid && rx_take)
         begin
            wrap_reg <= (uart_rx_data == `RMC_CMD_WRAP);
            cmd_reg  <= uart_rx_data;
         end
         if ((state_reg == ST_HDR) && uart_rx_valid)
         begin
            cmd_reg <= uart_rx_data;
         end
         if ((state_reg == ST_ADDR) && uart_rx_valid)
         begin
            addr_reg <= uart_rx_data;
         end
         if ((state_reg == ST_LEN) && uart_rx_valid)
         begin
            len_reg <= uart_rx_data;
            cnt_reg <= 8'h00;
         end
         if (wr_stb)
         begin
            cnt_reg <= cnt_reg + 8'h01;
         end
         if (rsp_load)
         begin
            idx_reg <= (idx_reg == rsp_last) ? 8'h00 : idx_reg + 8'h01;
         end
      end
   end

   // ****************************************
   // Register file: live copy and kept copy
   // ****************************************
   assign wr_stb = (state_reg == ST_DATA) & uart_rx_valid;
   assign wr_ptr = addr_reg + cnt_reg;

   genvar g;
   generate
      for (g = 0; g < `RMC_REG_NUM; g = g + 1)
      begin : g_reg
         reg  [7:0] live_reg;
         reg  [7:0] kept_reg;
         wire [7:0] rst_val;
         wire       hit;

         assign rst_val = (g == `RMC_REG0_ADDR) ? `RMC_REG0_RST : `RMC_REG_RST;
         assign hit     = wr_stb & (wr_ptr == g);

         always @(posedge clk)
         begin
            if (srst)
            begin
               live_reg <= rst_val;
               kept_reg <= rst_val;
            end
            else
            begin
               if (reload_reg && (reload_idx_reg == g))
               begin
                  live_reg <= kept_reg;
               end
               else if (hit)
               begin
                  live_reg <= uart_rx_data;
               end
               // Temporary writes never reach the kept copy
               if (hit && (cmd_reg == `RMC_CMD_SET))
               begin
                  kept_reg <= uart_rx_data;
               end
            end
         end

         assign live_q[g]             = live_reg;
         assign cfg_live[8*g+7:8*g]   = live_reg;
         assign cfg_stored[8*g+7:8*g] = kept_reg;
      end
   endgenerate

endmodule // rmc_ctrl

`default_nettype wire

//--- rmc_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rmc_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
)
(
   input  wire             clk,
   input  wire             srst,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             empty
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign empty     = ~out_valid;
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers wrap naturally because DEPTH is a power of two
   always @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push & ~pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop & ~push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule // rmc_fifo

`default_nettype wire

//--- rmc_host.sv
// Host controller model: mode pins and the decoded serial byte stream
`timescale 1ns/1ps
`default_nettype none

module rmc_host
#(
   parameter HOLD = 4
)
(
   input  wire logic       clk,
   input  wire logic       busy_n,
   input  wire logic       uart_rx_ready,
   input  wire logic       uart_tx_valid,
   input  wire logic [7:0] uart_tx_data,
   output var  logic       mode_select_low,
   output var  logic       mode_select_high,
   output var  logic       uart_rx_valid,
   output var  logic [7:0] uart_rx_data,
   output var  logic       uart_tx_ready
);
   logic [7:0] rxq [$];
   logic       stall;
   logic [1:0] cnt;

   initial
   begin
      {mode_select_high, mode_select_low} = 2'h0;
      uart_rx_valid = 1'b0;
      uart_rx_data = 8'h00;
      uart_tx_ready = 1'b1;
      stall = 1'b0;
      cnt = 2'h0;
   end

   // A slow host takes one response byte in four cycles
   always @(negedge clk)
   begin
      cnt <= cnt + 2'h1;
      uart_tx_ready <= !stall || cnt == 2'h3;
   end

   always @(posedge clk)
   begin
      if (uart_tx_valid && uart_tx_ready)
         rxq.push_back(uart_tx_data);
   end

   // Pins move only after busy_n has stayed high; HOLD stands in for the long settle time
   task set_mode(input logic [1:0] m);
      int n;
      begin
         n = 0;
         while (n < HOLD)
         begin
            @(negedge clk);
            n = busy_n ? n + 1 : 0;
         end
         {mode_select_high, mode_select_low} = m;
      end
   endtask

   task pins_now(input logic [1:0] m);
      begin
         @(negedge clk);
         {mode_select_high, mode_select_low} = m;
      end
   endtask

   // Bytes stand for whole characters of the fixed serial format
   task send(input logic [7:0] b);
      begin
         @(negedge clk);
         uart_rx_valid = 1'b1;
         uart_rx_data = b;
         #1;
         while (!uart_rx_ready)
            @(negedge clk);
         @(posedge clk);
      end
   endtask

   task release_rx;
      begin
         @(negedge clk);
         uart_rx_valid = 1'b0;
         uart_rx_data = ~uart_rx_data;
      end
   endtask
endmodule // rmc_host
`default_nettype wire

//--- rmc_regs.vh
// Constants for the radio modem mode controller and command interpreter
`ifndef RMC_REGS_VH
`define RMC_REGS_VH

// ****************************************
// Mode pin codes {high, low}
// ****************************************
`define RMC_MODE_NORMAL    2'h0
`define RMC_MODE_WOR       2'h1
`define RMC_MODE_CFG       2'h2
`define RMC_MODE_SLEEP     2'h3

// ****************************************
// Command and response bytes
// ****************************************
`define RMC_CMD_SET        8'hC0
`define RMC_CMD_READ       8'hC1
`define RMC_CMD_TEMP       8'hC2
`define RMC_CMD_WRAP       8'hCF
`define RMC_RSP_HDR        8'hC1
`define RMC_RSP_ERR        8'hFF

// ****************************************
// Register file
// ****************************************
`define RMC_REG_NUM        9
`define RMC_REG_NUM_B      8'h09
`define RMC_REG_IDX_W      4
`define RMC_REG0_ADDR      4'h3
`define RMC_REG0_RST       8'h62
`define RMC_REG_RST        8'h00

// ****************************************
// Data buffer
// ****************************************
`define RMC_FIFO_WIDTH     8
`define RMC_FIFO_DEPTH     16
`define RMC_FIFO_AW        4

`endif

//--- tb_top.sv
// Self-checking testbench for the mode controller and command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.vh"

module tb_top;
   logic       clk, srst, wor_tx_role, radio_tx_ready, radio_busy, radio_rx_valid;
   logic       mode_select_low, mode_select_high, uart_rx_valid, uart_rx_ready;
   logic       uart_tx_valid, uart_tx_ready, radio_tx_valid, radio_tx_wake;
   logic       radio_rx_ready, radio_tx_en, radio_rx_en, busy_n;
   logic [7:0] radio_rx_data, uart_rx_data, uart_tx_data, radio_tx_data;
   logic [1:0] mode;
   logic [8*`RMC_REG_NUM-1:0] cfg_live, cfg_stored;
   logic [7:0] txq [$];
   int         n_errors = 0;
   int         cmp_count = 0;
   int         cyc = 0;

   rmc_ctrl rmc_ctrl_inst
   (
      .clk(clk), .srst(srst), .mode_select_low(mode_select_low),
      .mode_select_high(mode_select_high), .wor_tx_role(wor_tx_role),
      .uart_rx_valid(uart_rx_valid), .uart_rx_ready(uart_rx_ready), .uart_rx_data(uart_rx_data),
      .uart_tx_valid(uart_tx_valid), .uart_tx_ready(uart_tx_ready), .uart_tx_data(uart_tx_data),
      .radio_tx_valid(radio_tx_valid), .radio_tx_ready(radio_tx_ready),
      .radio_tx_data(radio_tx_data), .radio_tx_wake(radio_tx_wake), .radio_busy(radio_busy),
      .radio_rx_valid(radio_rx_valid), .radio_rx_ready(radio_rx_ready),
      .radio_rx_data(radio_rx_data), .radio_tx_en(radio_tx_en), .radio_rx_en(radio_rx_en),
      .busy_n(busy_n), .mode(mode), .cfg_live(cfg_live), .cfg_stored(cfg_stored)
   );

   rmc_host rmc_host_inst
   (
      .clk(clk), .busy_n(busy_n), .uart_rx_ready(uart_rx_ready),
      .uart_tx_valid(uart_tx_valid), .uart_tx_data(uart_tx_data),
      .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
      .uart_rx_valid(uart_rx_valid), .uart_rx_data(uart_rx_data), .uart_tx_ready(uart_tx_ready)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (radio_tx_valid && radio_tx_ready)
         txq.push_back(radio_tx_data);
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         conclude;
      end
   end

   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask

   task check(input string nm, input logic [71:0] exp, input logic [71:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp)
         begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %0h got %0h", nm, exp, got);
         end
      end
   endtask

   task hwait(input int n);
      int i;
      begin
         for (i = 0; i < 400 && rmc_host_inst.rxq.size() < n; i++)
            @(negedge clk);
      end
   endtask

   task go_mode(input logic [1:0] m);
      int i;
      begin
         rmc_host_inst.set_mode(m);
         for (i = 0; i < 50 && mode !== m; i++)
            @(negedge clk);
         check("mode", m, mode);
      end
   endtask

   task rsend(input logic [7:0] b);
      begin
         rmc_host_inst.rxq.delete();
         @(negedge clk);
         radio_rx_valid = 1'b1;
         radio_rx_data = b;
         #1;
         while (!radio_rx_ready)
            @(negedge clk);
         @(posedge clk);
         @(negedge clk);
         radio_rx_valid = 1'b0;
         radio_rx_data = ~b;
         hwait(1);
         check("radio_to_serial", b, rmc_host_inst.rxq[0]);
      end
   endtask

   // Command and expected reply are packed first byte highest, right aligned
   task cmd(input logic [95:0] s, input int ns, input logic [95:0] e, input int ne);
      int i;
      begin
         rmc_host_inst.rxq.delete();
         for (i = 0; i < ns; i++)
            rmc_host_inst.send(s[8*(ns-1-i) +: 8]);
         rmc_host_inst.release_rx();
         hwait(ne);
         check("rsp_len", ne, rmc_host_inst.rxq.size());
         for (i = 0; i < ne && i < rmc_host_inst.rxq.size(); i++)
            check("rsp_byte", e[8*(ne-1-i) +: 8], rmc_host_inst.rxq[i]);
      end
   endtask

   task t_normal;
      int i;
      begin
         go_mode(2'h0);
         check("radio_en", 2'h3, {radio_tx_en, radio_rx_en});
         txq.delete();
         radio_tx_ready = 1'b0;
         for (i = 0; i < 16; i++)
            rmc_host_inst.send(8'h10 + i[7:0]);
         rmc_host_inst.release_rx();
         check("full_refuse", 1'b0, uart_rx_ready);
         @(negedge clk);
         radio_tx_ready = 1'b1;
         for (i = 0; i < 100 && txq.size() < 16; i++)
            @(negedge clk);
         check("tx_count", 16, txq.size());
         for (i = 0; i < txq.size(); i++)
            check("tx_byte", 8'h10 + i[7:0], txq[i]);
         check("no_reply", 0, rmc_host_inst.rxq.size());
         rsend(8'h5A);
         $display("t_normal done");
      end
   endtask

   task t_wake;
      int i;
      begin
         go_mode(2'h1);
         wor_tx_role = 1'b1;
         txq.delete();
         rmc_host_inst.send(8'h3C);
         rmc_host_inst.release_rx();
         for (i = 0; i < 50 && txq.size() < 1; i++)
            @(negedge clk);
         check("wake_flag", 1'b1, radio_tx_wake);
         check("wake_tx", 8'h3C, txq[0]);
         wor_tx_role = 1'b0;
         #1;
         check("wake_rx_role", 1'b0, radio_tx_wake);
         rsend(8'hA5);
         $display("t_wake done");
      end
   endtask

   task t_defer;
      int i;
      begin
         go_mode(2'h0);
         radio_tx_ready = 1'b0;
         radio_busy = 1'b1;
         txq.delete();
         rmc_host_inst.send(8'h44);
         rmc_host_inst.release_rx();
         check("busy", 1'b0, busy_n);
         rmc_host_inst.pins_now(2'h2);
         repeat (20) @(negedge clk);
         check("mode_held", 2'h0, mode);
         radio_busy = 1'b0;
         radio_tx_ready = 1'b1;
         for (i = 0; i < 50 && mode !== 2'h2; i++)
            @(negedge clk);
         check("mode_late", 2'h2, mode);
         check("pending_tx", 8'h44, txq[0]);
         $display("t_defer done");
      end
   endtask

   task t_cfg;
      begin
         go_mode(2'h2);
         check("radio_off", 2'h0, {radio_tx_en, radio_rx_en});
         cmd(24'hC10301, 3, 32'hC1030162, 4);
         rmc_host_inst.stall = 1'b1;
         cmd(40'hC00502AABB, 5, 40'hC10502AABB, 5);
         check("kept_set", 16'hBBAA, cfg_stored[55:40]);
         cmd(32'hC2060177, 4, 32'hC1060177, 4);
         check("live_tmp", 8'h77, cfg_live[55:48]);
         check("kept_tmp", 8'hBB, cfg_stored[55:48]);
         rmc_host_inst.stall = 1'b0;
         cmd(40'hCFCFC10502, 5, 56'hCFCFC10502AA77, 7);
         cmd(16'hCF00, 2, {3{8'hFF}}, 3);
         cmd({8'hC5}, 1, {3{8'hFF}}, 3);
         cmd({8'hC1, 8'h08, 8'h02}, 3, {3{8'hFF}}, 3);
         cmd({8'hC1, 8'h03, 8'h00}, 3, {3{8'hFF}}, 3);
         $display("t_cfg done");
      end
   endtask

   task t_sleep;
      int i;
      int lows;
      begin
         go_mode(2'h3);
         check("sleep_radio", 2'h0, {radio_tx_en, radio_rx_en, radio_rx_ready});
         check("sleep_serial", 1'b0, uart_rx_ready);
         rmc_host_inst.set_mode(2'h2);
         lows = 0;
         for (i = 0; i < 40; i++)
         begin
            @(negedge clk);
            lows = lows + (busy_n ? 0 : 1);
         end
         check("reload_len", `RMC_REG_NUM, lows);
         check("mode_cfg", 2'h2, mode);
         check("reloaded", 16'hBBAA, cfg_live[55:40]);
         check("reg3", 8'h62, cfg_live[31:24]);
         $display("t_sleep done");
      end
   endtask

   initial
   begin
      srst = 1'b1;
      wor_tx_role = 1'b0;
      radio_tx_ready = 1'b1;
      radio_busy = 1'b0;
      radio_rx_valid = 1'b0;
      radio_rx_data = 8'h00;
      repeat (8) @(negedge clk);
      srst = 1'b0;
      t_normal;
      t_wake;
      t_defer;
      t_cfg;
      t_sleep;
      conclude;
   end
endmodule // tb_top
`default_nettype wire
